// >>> scan_pkg.sv
package scan_pkg;
  // drive timing, in ns as printed
  localparam int CLK_PERIOD_NS = 10;
  localparam int PHASE_HIGH_NS = 200;
  localparam int START_HIGH_NS = 200;
  localparam int START_OVERLAP_NS = 200;
  localparam int EDGE_BASE_NS = 20;
  localparam int INT_RESET_DELAY_NS = 50;
  localparam int GATE_PULSE_NS = 5000;
  localparam int TRANSITION_NS = 20;
  // cycle counts, least times rounded up
  localparam int PHASE_HIGH_CYC = (PHASE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int START_HIGH_CYC = (START_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int START_OVERLAP_CYC = (START_OVERLAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_NS = (TRANSITION_NS > EDGE_BASE_NS) ? TRANSITION_NS - EDGE_BASE_NS : 0;
  localparam int GAP_CYC = ((GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1) ? 1
                           : (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INT_RESET_DELAY_CYC = (INT_RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GATE_PULSE_CYC = (GATE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int DEFAULT_PIXELS = 512;
  localparam int CNT_W = 16;
endpackage

// >>> scan_if.sv
`timescale 1ns/1ps
interface scan_if;
  logic phase1;
  logic phase2;
  logic scan_start_pulse;
  logic gate_reset;
  logic video_valid;
  logic [15:0] video;
  logic scan_done_n;
  modport sensor (input phase1, phase2, scan_start_pulse, gate_reset, output video_valid, video, scan_done_n);
  modport driver (output phase1, phase2, scan_start_pulse, gate_reset, input video_valid, video, scan_done_n);
endinterface

// >>> scan_driver.sv
`timescale 1ns/1ps
// Contract
// [R01] video appears at each phase-two rise
// [R02] start interval sets integration time
// [R03] phases never both high
// [R04] gap between phases for slow edges
// [R05] each phase high at least 200 ns
// [R06] start high restarts shift register scan
// [R07] start high 200 ns, overlapping phase two
// [R08] one phase-two fall per start pulse
// [R09] active-low done after last pixel
// [R10] positive-going start and clock pulses
// [R11] gate high resets all photodiodes
// [R12] gate pulse longer than 5 us
// [R13] integrator reset 50 ns after phase-two fall
// [R14] tag samples with pixel index
module scan_driver import scan_pkg::*; #(
  parameter int PIXELS = DEFAULT_PIXELS,
  parameter int FRAME_GAP = 4
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic NRST,
  // user control
  input wire logic START,
  input wire logic GLOBAL_RESET,
  // user results
  output logic SAMPLE_VALID,
  output logic [15:0] SAMPLE,
  output logic [CNT_W-1:0] SAMPLE_INDEX,
  output logic FRAME_DONE,
  output logic INT_RESET,
  output logic BUSY,
  // sensor side
  scan_if.driver link
);
  localparam int TMR_W = 16;
  // overlap and width both hold while start is high through one p2 period
  localparam int P2_CYC = (START_OVERLAP_CYC > PHASE_HIGH_CYC) ? START_OVERLAP_CYC : PHASE_HIGH_CYC;
  // every count must fit the frame timer and the pixel counter
  if (PIXELS < 2 || PIXELS >= (1 << CNT_W)) begin : g_bad_pixels
    $error("PIXELS out of range");
  end
  if (FRAME_GAP < 0 || FRAME_GAP >= (1 << TMR_W)) begin : g_bad_gap
    $error("FRAME_GAP out of range");
  end
  if (P2_CYC >= (1 << TMR_W) || GAP_CYC >= (1 << TMR_W)) begin : g_bad_phase
    $error("phase timing does not fit the timer");
  end
  if (GATE_PULSE_CYC >= (1 << TMR_W) || INT_RESET_DELAY_CYC + 1 >= (1 << TMR_W)) begin : g_bad_aux
    $error("auxiliary pulse timing does not fit the timer");
  end
  typedef enum {IDLE, GAP1, P1, GAP2, P2, REST} st_t;
  // frame sequencer
  st_t state;
  st_t next_state;
  logic [TMR_W-1:0] tmr;
  logic [TMR_W-1:0] next_tmr;
  logic [CNT_W-1:0] pix;
  logic [CNT_W-1:0] next_pix;
  logic first;
  logic next_first;
  logic next_phase1;
  logic next_phase2;
  logic next_start;
  logic next_busy;
  // auxiliary pulses and readback
  logic [TMR_W-1:0] gate_tmr;
  logic [TMR_W-1:0] irst_tmr;
  logic done_s1;
  wire tmr_zero = (tmr == '0);
  wire [TMR_W-1:0] tmr_dec = tmr_zero ? tmr : tmr - TMR_W'(1);
  // the load period carries no pixel, so it is not counted
  wire last_period = !first && (pix == CNT_W'(PIXELS));
  wire p2_end = (state == P2) && tmr_zero;
  wire [CNT_W-1:0] pix_tag = pix + CNT_W'(1);
  wire gate_idle = (gate_tmr == '0);
  wire gate_start = GLOBAL_RESET && gate_idle;
  wire irst_fire = (irst_tmr == TMR_W'(1));
  wire done_fall = done_s1 && !link.scan_done_n;
  always_comb begin
    next_state = state;
    next_tmr = tmr_dec;
    next_pix = pix;
    next_first = first;
    next_phase1 = link.phase1;
    next_phase2 = link.phase2;
    next_start = link.scan_start_pulse;
    next_busy = BUSY;
    case (state)
      IDLE: begin
        // start is refused outside idle, so a frame is never cut short
        if (START) begin
          next_state = GAP1;
          next_busy = 1'b1;
          next_first = 1'b1;
          next_pix = '0;
          next_tmr = TMR_W'(GAP_CYC);
        end
      end
      GAP1: begin
        if (tmr_zero) begin
          next_state = P1;
          next_phase1 = 1'b1; // [R10]
          next_tmr = TMR_W'(PHASE_HIGH_CYC); // [R05]
        end
      end
      P1: begin
        if (tmr_zero) begin
          next_state = GAP2;
          next_phase1 = 1'b0;
          next_tmr = TMR_W'(GAP_CYC); // [R04]
        end
      end
      GAP2: begin
        if (tmr_zero) begin
          next_state = P2;
          next_phase2 = 1'b1; // [R03]
          next_start = first; // [R06] [R07]
          next_tmr = TMR_W'(P2_CYC); // [R05] [R07]
        end
      end
      P2: begin
        if (tmr_zero) begin
          next_phase2 = 1'b0;
          next_start = 1'b0; // [R08]
          next_first = 1'b0;
          if (!first) next_pix = pix_tag; // [R14]
          if (last_period) begin
            next_state = REST;
            next_tmr = TMR_W'(FRAME_GAP); // [R02]
          end else begin
            next_state = GAP1;
            next_tmr = TMR_W'(GAP_CYC);
          end
        end
      end
      REST: begin
        if (tmr_zero) begin
          next_state = IDLE;
          next_busy = 1'b0;
        end
      end
      default: next_state = IDLE;
    endcase
  end
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      state <= IDLE;
      tmr <= '0;
      pix <= '0;
      first <= 1'b0;
      BUSY <= 1'b0;
    end else begin
      state <= next_state;
      tmr <= next_tmr;
      pix <= next_pix;
      first <= next_first;
      BUSY <= next_busy;
    end
  end
  // link pins straight from flops
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      link.phase1 <= 1'b0;
      link.phase2 <= 1'b0;
      link.scan_start_pulse <= 1'b0;
    end else begin
      link.phase1 <= next_phase1;
      link.phase2 <= next_phase2; // [R03]
      link.scan_start_pulse <= next_start; // [R07]
    end
  end
  // global reset gate pulse, one cycle past the minimum width
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      gate_tmr <= '0;
      link.gate_reset <= 1'b0;
    end else if (gate_start) begin
      gate_tmr <= TMR_W'(GATE_PULSE_CYC); // [R12]
      link.gate_reset <= 1'b1; // [R11]
    end else if (!gate_idle) begin
      gate_tmr <= gate_tmr - TMR_W'(1);
      link.gate_reset <= (gate_tmr != TMR_W'(1));
    end
  end
  // integrator reset waits past each phase-two fall, drops at the next p2
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      irst_tmr <= '0;
      INT_RESET <= 1'b0;
    end else begin
      if (p2_end) irst_tmr <= TMR_W'(INT_RESET_DELAY_CYC + 1);
      else if (irst_tmr != '0) irst_tmr <= irst_tmr - TMR_W'(1);
      INT_RESET <= irst_fire || (INT_RESET && state != P2); // [R13]
    end
  end
  // sensor outputs come from logic on this clock, so no synchroniser
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      SAMPLE_VALID <= 1'b0;
      SAMPLE <= '0;
      SAMPLE_INDEX <= '0;
      FRAME_DONE <= 1'b0;
      done_s1 <= 1'b1;
    end else begin
      SAMPLE_VALID <= link.video_valid; // [R01]
      SAMPLE <= link.video;
      if (link.video_valid) SAMPLE_INDEX <= pix_tag; // [R14]
      done_s1 <= link.scan_done_n;
      FRAME_DONE <= done_fall; // [R09]
    end
  end
endmodule // scan_driver

// >>> scan_sensor.sv
`timescale 1ns/1ps
module scan_sensor import scan_pkg::*; #(
  parameter int PIXELS = DEFAULT_PIXELS
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic NRST,
  // light input per addressed pixel
  input wire logic [15:0] LIGHT,
  // photodiode state
  output logic [CNT_W-1:0] ADDR,
  output logic CLEARED,
  // driver side
  scan_if.sensor link
);
  if (PIXELS < 2 || PIXELS >= (1 << CNT_W)) begin : g_bad_pixels
    $error("PIXELS out of range");
  end
  logic p2_a, p2_b, p2_c, st_a, st_b, st_c, g_a, g_b;
  logic [CNT_W-1:0] addr;
  logic loaded, active;
  wire p2_rise = p2_b && !p2_c;
  wire p2_fall = !p2_b && p2_c;
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      p2_a <= 1'b0;
      p2_b <= 1'b0;
      p2_c <= 1'b0;
      st_a <= 1'b0;
      st_b <= 1'b0;
      st_c <= 1'b0;
      g_a <= 1'b0;
      g_b <= 1'b0;
    end else begin
      p2_a <= link.phase2;
      p2_b <= p2_a;
      p2_c <= p2_b;
      st_a <= link.scan_start_pulse;
      st_b <= st_a;
      st_c <= st_b;
      g_a <= link.gate_reset;
      g_b <= g_a;
    end
  end
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      addr <= '0;
      loaded <= 1'b0;
      active <= 1'b0;
      link.video_valid <= 1'b0;
      link.video <= 16'h0000;
      link.scan_done_n <= 1'b1;
      ADDR <= '0;
      CLEARED <= 1'b0;
    end else begin
      link.video_valid <= 1'b0;
      // start may drop with phase two, so look at it one stage back
      if (p2_fall && st_c) begin
        loaded <= 1'b1; // [R06] [R02]
        addr <= '0;
        active <= 1'b0;
      end else if (p2_rise && loaded) begin
        active <= 1'b1;
        loaded <= 1'b0;
        addr <= CNT_W'(1);
        link.video_valid <= 1'b1; // [R01]
        link.video <= g_b ? 16'h0000 : LIGHT;
      end else if (p2_rise && active) begin
        if (addr == CNT_W'(PIXELS)) begin
          active <= 1'b0;
          link.scan_done_n <= 1'b0; // [R09]
        end else begin
          addr <= addr + 1'b1;
          link.video_valid <= 1'b1; // [R01]
          link.video <= g_b ? 16'h0000 : LIGHT; // [R11]
        end
      end else if (p2_fall) begin
        link.scan_done_n <= 1'b1;
      end
      ADDR <= addr;
      CLEARED <= g_b; // [R11]
    end
  end
endmodule // scan_sensor

// >>> scan_props.sv
`timescale 1ns/1ps
module scan_props (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic NRST,
  // link
  input wire logic phase1,
  input wire logic phase2,
  input wire logic scan_start_pulse,
  input wire logic gate_reset,
  input wire logic video_valid,
  input wire logic [15:0] video,
  input wire logic scan_done_n
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  a_no_overlap: assert property (!(phase1 && phase2)) else $error("phase overlap");
  a_phase_gap: assert property ($fell(phase1) |-> !phase2) else $error("no gap");
  a_p1_width: assert property ($fell(phase1) |-> $past(phase1, 20)) else $error("phase1 short");
  a_p2_width: assert property ($fell(phase2) |-> $past(phase2, 20)) else $error("phase2 short");
  a_start_p2: assert property ($rose(scan_start_pulse) |-> $rose(phase2)) else $error("start off");
  a_start_hold: assert property ($fell(scan_start_pulse) |-> $past(phase2, 20) && $past(scan_start_pulse, 20))
    else $error("start short");
  a_video_p2: assert property (video_valid |-> phase2) else $error("video off");
  a_done_low: assert property ($fell(scan_done_n) |-> phase2 ##1 !scan_done_n [*8]) else $error("done short");
  a_gate_width: assert property ($fell(gate_reset) |-> $past(gate_reset, 500)) else $error("gate short");
endmodule // scan_props

// >>> linear_sensor_scan_drive_test.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; $display("[ERR] %0t %h %h", $time, g, e); end end
module linear_sensor_scan_drive_test;
  import scan_pkg::*;
  localparam int NPIX = 4;
  logic CORE_CLK = 0, NRST = 0, START = 0, GLOBAL_RESET = 0;
  logic [15:0] LIGHT = 16'h0000;
  logic sample_valid, frame_done, int_reset, busy, cleared;
  logic [15:0] sample;
  logic [CNT_W-1:0] sample_index;
  logic [CNT_W-1:0] addr;
  logic [32:0] note;
  logic [31:0] rnd;
  logic [32:0] notes[$];
  int err_total = 0, checked = 0, seed = 14, low_cnt = 0;
  scan_if link_if();
  scan_driver #(.PIXELS(NPIX)) scan_driver_i (.CORE_CLK(CORE_CLK), .NRST(NRST), .START(START),
    .GLOBAL_RESET(GLOBAL_RESET), .SAMPLE_VALID(sample_valid), .SAMPLE(sample), .SAMPLE_INDEX(sample_index),
    .FRAME_DONE(frame_done), .INT_RESET(int_reset), .BUSY(busy), .link(link_if));
  scan_sensor #(.PIXELS(NPIX)) scan_sensor_i (.CORE_CLK(CORE_CLK), .NRST(NRST), .LIGHT(LIGHT), .ADDR(addr),
    .CLEARED(cleared), .link(link_if));
  scan_props scan_props_i (.CORE_CLK(CORE_CLK), .NRST(NRST), .phase1(link_if.phase1), .phase2(link_if.phase2),
    .scan_start_pulse(link_if.scan_start_pulse), .gate_reset(link_if.gate_reset), .video_valid(link_if.video_valid),
    .video(link_if.video), .scan_done_n(link_if.scan_done_n));
  always #5 CORE_CLK = ~CORE_CLK;
  // empty queue yields a note no result can match
  always @(posedge CORE_CLK) begin
    low_cnt <= link_if.phase2 ? 0 : low_cnt + 1;
    if (int_reset === 1'b1) `CHK(low_cnt >= INT_RESET_DELAY_CYC, 1'b1)
    if (sample_valid === 1'b1 || frame_done === 1'b1) begin
      if (notes.size() == 0) notes.push_back(33'h1ffffffff);
      note = notes.pop_front();
      `CHK(frame_done ? {1'b1, 32'h0} : {1'b0, sample_index, sample}, note)
    end
  end
  task automatic frame(input logic [15:0] light, input logic poke);
    int n;
    for (n = 1; n <= NPIX; n++) notes.push_back({1'b0, n[CNT_W-1:0], light});
    notes.push_back({1'b1, 32'h0});
    LIGHT <= light;
    START <= 1'b1;
    @(posedge CORE_CLK);
    START <= 1'b0;
    repeat (40) @(posedge CORE_CLK);
    START <= poke; // must be refused mid-frame
    @(posedge CORE_CLK);
    START <= 1'b0;
    for (n = 0; n < 5000 && busy !== 1'b0; n++) @(posedge CORE_CLK);
    repeat (3) @(posedge CORE_CLK);
    `CHK(notes.size() == 0, 1'b1)
    `CHK({busy, addr}, {1'b0, CNT_W'(NPIX)})
    $display("frame %h end", light);
  endtask
  task automatic end_sim;
    $display("checked %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge CORE_CLK);
    NRST <= 1'b1;
    @(posedge CORE_CLK);
    frame(16'h0000, 1'b0);
    frame(16'hffff, 1'b1);
    repeat (3) begin
      rnd = $random(seed);
      frame(rnd[15:0], rnd[16]);
    end
    GLOBAL_RESET <= 1'b1;
    repeat (20) @(posedge CORE_CLK);
    `CHK(cleared, 1'b1)
    GLOBAL_RESET <= 1'b0;
    repeat (600) @(posedge CORE_CLK);
    `CHK({link_if.gate_reset, cleared}, 2'b00)
    $display("gate end");
    end_sim;
  end
  initial begin
    #200000;
    err_total++;
    end_sim;
  end
endmodule // linear_sensor_scan_drive_test
